// ### rtl/usb_out_ep_pkg.sv
// usb_out_ep_pkg: register map, field positions, reset values and counts
// for the out endpoint control and status block.
// assumes a 32-bit ahb-lite slave decoding the low address byte.
//
// Operation
// - a one written to clear_toggle_bit zeroes the endpoint data toggle
// - clear_toggle_bit always reads back as zero
// - clearing stall_request_bit ends stalling; the bit is ignored in iso mode
// - a one written to the flush bit discards the next waiting packet
// - a flush resets the fifo read pointer and clears packet_ready_flag
// - hardware clears the flush bit when the flush has finished
// - overrun_flag sets when an arriving iso packet finds the fifo full
// - overrun_flag matters in iso mode and holds until software clears it
// - with double buffering, fifo_full_flag is one when two packets wait
// - without double buffering, fifo_full_flag is one with one packet
// - a received out packet sets packet_ready_flag and raises an interrupt
// - while stall_request_bit is one every non-iso out request gets a stall
// - each stall sent sets stall_sent_flag and interrupts; firmware clears it
// - an iso packet with crc error is stored, flagged ready and data_error_flag
package usb_out_ep_pkg;
    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [7:0] CTRL_LOW_OFS = 8'h14;
    localparam logic [7:0] EP_CFG_OFS = 8'h18;
    localparam logic [7:0] INT_STAT_OFS = 8'h1C;
    localparam logic [7:0] INT_MASK_OFS = 8'h20;
    // ----------------------------------------
    // fields of out_endpoint_control_low
    // ----------------------------------------
    localparam int CLR_TOGGLE_POS = 7;
    localparam int STALL_SENT_POS = 6;
    localparam int STALL_REQ_POS = 5;
    localparam int FLUSH_POS = 4;
    localparam int DATA_ERR_POS = 3;
    localparam int OVERRUN_POS = 2;
    localparam int FIFO_FULL_POS = 1;
    localparam int PKT_RDY_POS = 0;
    localparam logic [7:0] CTRL_LOW_RESET = 8'h00;
    // ----------------------------------------
    // endpoint config, interrupt status and mask
    // ----------------------------------------
    localparam int CFG_ISO_POS = 0;
    localparam int CFG_DBL_POS = 1;
    localparam logic [1:0] CFG_RESET = 2'h0;
    localparam int INT_PKT_POS = 0;
    localparam int INT_STALL_POS = 1;
    localparam int INT_OVR_POS = 2;
    localparam logic [2:0] INT_RESET = 3'h0;
    // ----------------------------------------
    // counts and bus codes
    // ----------------------------------------
    localparam int FLUSH_CYCLES = 4;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// ### rtl/flush_if.sv
// flush_if: handshake between the register logic and the flush sequencer.
// assumes both ends run on core_clk.
`timescale 1ns/1ps
interface flush_if;
    logic start;
    logic done;
    logic rd_ptr_rst;
    modport ctrl (output start, input done, input rd_ptr_rst);
    modport seq (input start, output done, output rd_ptr_rst);
endinterface

// ### rtl/flush_seq.sv
// flush_seq: timed flush of one packet from the out fifo.
// assumes start is a one-cycle pulse, never raised while a flush runs.
`timescale 1ns/1ps
module flush_seq
    import usb_out_ep_pkg::*;
#(
    parameter int CYCLES = FLUSH_CYCLES
) (
    input wire logic core_clk,
    input wire logic rstn,
    flush_if.seq fl
);
    localparam int DONE_LAT = CYCLES + 1;
    typedef enum logic [1:0] {FL_IDLE = 2'b00, FL_RUN = 2'b01} fl_state_e;
    typedef struct packed {
        fl_state_e st;
        logic [7:0] cnt;
        logic done;
        logic rd_ptr_rst;
    } fl_s;
    fl_s q;
    fl_s d;

    // read pointer rewinds at once; done follows after the drain time
    always_comb begin
        d = q;
        d.done = 1'b0;
        d.rd_ptr_rst = 1'b0;
        case (q.st)
            FL_IDLE: begin
                if (fl.start) begin
                    d.st = FL_RUN;
                    d.cnt = 8'(CYCLES - 1);
                    d.rd_ptr_rst = 1'b1;
                end
            end
            FL_RUN: begin
                if (q.cnt == 8'h00) begin
                    d.st = FL_IDLE;
                    d.done = 1'b1;
                end else begin
                    d.cnt = q.cnt - 8'h01;
                end
            end
            default: d.st = FL_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '{st: FL_IDLE, cnt: 8'h00, done: 1'b0, rd_ptr_rst: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign fl.done = q.done;
    assign fl.rd_ptr_rst = q.rd_ptr_rst;

    AST_FLUSH_DONE_LAT: assert property (@(posedge core_clk) disable iff (!rstn)
        (fl.start && q.st == FL_IDLE) |-> ##DONE_LAT fl.done)
        else $error("flush done not at fixed latency");
endmodule // flush_seq

// ### rtl/usb_out_ep_ctrl.sv
// usb_out_ep_ctrl: control and status of one out endpoint behind an
// ahb-lite slave, with packet accounting and handshake choice.
// assumes the serial engine runs on core_clk and pulses sie_rx_valid
// once per received out data packet, with its error qualifiers.
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
module usb_out_ep_ctrl
    import usb_out_ep_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic sie_rx_valid,
    input wire logic sie_rx_crc_err,
    input wire logic sie_rx_stuff_err,
    output logic hs_ack,
    output logic hs_nak,
    output logic hs_stall,
    output logic fifo_store,
    output logic fifo_drop,
    output logic fifo_rd_ptr_rst,
    output logic data_toggle,
    output logic irq
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic iso;
        logic dbl;
        logic toggle;
        logic stall_req;
        logic stall_sent;
        logic flush;
        logic data_err;
        logic overrun;
        logic pkt_rdy;
        logic [1:0] pkt_cnt;
        logic [2:0] int_stat;
        logic [2:0] int_mask;
        logic irq;
        logic hs_ack;
        logic hs_nak;
        logic hs_stall;
        logic store;
        logic drop;
        logic rd_ptr_rst;
        logic flush_start;
    } st_s;
    st_s q;
    st_s d;

    flush_if fl ();

    flush_seq #(
        .CYCLES(FLUSH_CYCLES)
    ) u_flush (
        .core_clk(core_clk),
        .rstn(rstn),
        .fl(fl)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    logic [1:0] cap;
    logic full;
    logic rx_err;
    logic [7:0] wdat;
    logic wr_ctrl;
    logic wr_cfg;
    logic wr_stat;
    logic wr_mask;
    logic addr_ok;
    logic rd_ctrl;

    // fifo depth in packets follows the double-buffer setting
    assign cap = q.dbl ? 2'h2 : 2'h1;
    assign full = (q.pkt_cnt == cap);
    assign rx_err = sie_rx_crc_err | sie_rx_stuff_err;
    assign wdat = hwdata[7:0];
    assign wr_ctrl = q.wr_pend && (q.wr_addr == CTRL_LOW_OFS);
    assign wr_cfg = q.wr_pend && (q.wr_addr == EP_CFG_OFS);
    assign wr_stat = q.wr_pend && (q.wr_addr == INT_STAT_OFS);
    assign wr_mask = q.wr_pend && (q.wr_addr == INT_MASK_OFS);
    assign addr_ok = hsel && htrans[1] && hready;
    // read of control-low taken this cycle; only the checks watch it
    assign rd_ctrl = addr_ok && !hwrite && (haddr[7:0] == CTRL_LOW_OFS);

    // read view of the control-low byte
    function automatic logic [7:0] ctrl_view(input st_s s, input logic f);
        logic [7:0] v;
        v = 8'h00;
        v[CLR_TOGGLE_POS] = 1'b0;
        v[STALL_SENT_POS] = s.stall_sent;
        v[STALL_REQ_POS] = s.stall_req;
        v[FLUSH_POS] = s.flush;
        v[DATA_ERR_POS] = s.data_err;
        v[OVERRUN_POS] = s.overrun;
        v[FIFO_FULL_POS] = f;
        v[PKT_RDY_POS] = s.pkt_rdy;
        return v;
    endfunction

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic inc;
        logic dec;
        logic sw_pop;
        logic [2:0] ev;
        inc = 1'b0;
        dec = 1'b0;
        sw_pop = 1'b0;
        ev = 3'h0;
        d = q;
        d.hreadyout = 1'b1;
        d.hrdata = 32'h0000_0000;
        d.hs_ack = 1'b0;
        d.hs_nak = 1'b0;
        d.hs_stall = 1'b0;
        d.store = 1'b0;
        d.drop = 1'b0;
        d.flush_start = 1'b0;
        d.rd_ptr_rst = fl.rd_ptr_rst;
        d.wr_pend = 1'b0;

        // address phase: reads answer next cycle, writes wait for hwdata
        if (addr_ok) begin
            if (hwrite) begin
                d.wr_pend = (hsize == HSIZE_WORD);
                d.wr_addr = haddr[7:0];
            end else begin
                case (haddr[7:0])
                    CTRL_LOW_OFS: d.hrdata = {24'h000000, ctrl_view(q, full)};
                    EP_CFG_OFS: d.hrdata = {30'h0, q.dbl, q.iso};
                    INT_STAT_OFS: d.hrdata = {29'h0, q.int_stat};
                    INT_MASK_OFS: d.hrdata = {29'h0, q.int_mask};
                    default: d.hrdata = 32'h0000_0000;
                endcase
            end
        end

        // software writes first, so that hardware sets below win over all but the toggle clear
        if (wr_ctrl) begin
            if (wdat[CLR_TOGGLE_POS]) begin
                d.toggle = 1'b0;
            end
            if (!wdat[STALL_SENT_POS]) begin
                d.stall_sent = 1'b0;
            end
            d.stall_req = wdat[STALL_REQ_POS];
            if (wdat[FLUSH_POS] && !q.flush) begin
                d.flush = 1'b1;
                d.flush_start = 1'b1;
            end
            if (!wdat[OVERRUN_POS]) begin
                d.overrun = 1'b0;
            end
            if (!wdat[PKT_RDY_POS] && q.pkt_rdy) begin
                sw_pop = 1'b1;
            end
        end
        if (wr_cfg) begin
            d.iso = wdat[CFG_ISO_POS];
            d.dbl = wdat[CFG_DBL_POS];
        end
        if (wr_stat) begin
            d.int_stat = q.int_stat & ~wdat[2:0];
        end
        if (wr_mask) begin
            d.int_mask = wdat[2:0];
        end

        // incoming out data packet; stall is a bulk/interrupt matter only
        if (sie_rx_valid) begin
            if (q.stall_req && !q.iso) begin
                d.hs_stall = 1'b1;
                d.stall_sent = 1'b1;
                ev[INT_STALL_POS] = 1'b1;
            end else if (!q.iso && rx_err) begin
                // corrupt bulk packet: no handshake, host retries
                d.hs_nak = 1'b0;
            end else if (!full) begin
                d.store = 1'b1;
                inc = 1'b1;
                if (!q.iso) begin
                    d.hs_ack = 1'b1;
                    d.toggle = ~q.toggle & ~(wr_ctrl & wdat[CLR_TOGGLE_POS]);
                end else if (rx_err) begin
                    d.data_err = 1'b1;
                end
            end else if (q.iso) begin
                d.overrun = 1'b1;
                ev[INT_OVR_POS] = 1'b1;
            end else begin
                d.hs_nak = 1'b1;
            end
        end

        // clearing the ready flag releases the packet and its error flag
        if (sw_pop) begin
            dec = 1'b1;
            if (!(d.store && q.iso && rx_err)) begin
                d.data_err = 1'b0;
            end
        end
        // flush completion drops one packet if any is held
        if (fl.done) begin
            d.flush = 1'b0;
            if (q.pkt_cnt != 2'h0) begin
                dec = 1'b1;
                d.drop = 1'b1;
            end
        end
        d.pkt_cnt = q.pkt_cnt + {1'b0, inc} - {1'b0, dec};

        // ready drops for a cycle after a pop, so a second packet re-interrupts
        if (q.flush || d.flush || dec) begin
            d.pkt_rdy = 1'b0;
        end else begin
            d.pkt_rdy = (q.pkt_cnt != 2'h0) || inc;
        end
        ev[INT_PKT_POS] = d.pkt_rdy && !q.pkt_rdy;

        // sticky interrupt status, level output
        d.int_stat = d.int_stat | ev;
        d.irq = |(d.int_stat & d.int_mask);
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign fl.start = q.flush_start;
    assign hrdata = q.hrdata;
    assign hreadyout = q.hreadyout;
    assign hresp = q.wr_pend & 1'b0;
    assign hs_ack = q.hs_ack;
    assign hs_nak = q.hs_nak;
    assign hs_stall = q.hs_stall;
    assign fifo_store = q.store;
    assign fifo_drop = q.drop;
    assign fifo_rd_ptr_rst = q.rd_ptr_rst;
    assign data_toggle = q.toggle;
    assign irq = q.irq;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    localparam int FL_MAX = FLUSH_CYCLES + 3;

    AST_CLR_TOGGLE: assert property (@(posedge core_clk) disable iff (!rstn)
        (wr_ctrl && wdat[CLR_TOGGLE_POS]) |=> !data_toggle)
        else $error("toggle not cleared");
    AST_TOGGLE_READS_ZERO: assert property (@(posedge core_clk) disable iff (!rstn)
        (addr_ok && !hwrite && haddr[7:0] == CTRL_LOW_OFS) |=> !hrdata[CLR_TOGGLE_POS])
        else $error("clear toggle bit read as one");
    AST_STALL_ANSWER: assert property (@(posedge core_clk) disable iff (!rstn)
        (sie_rx_valid && q.stall_req && !q.iso) |=> hs_stall && !hs_ack && !fifo_store)
        else $error("stall not answered");
    AST_ISO_NO_STALL: assert property (@(posedge core_clk) disable iff (!rstn)
        (sie_rx_valid && q.iso) |=> !hs_stall)
        else $error("stall sent in iso mode");
    AST_FLUSH_ENDS: assert property (@(posedge core_clk) disable iff (!rstn)
        (wr_ctrl && wdat[FLUSH_POS] && !q.flush) |=> q.flush ##[1:FL_MAX] !q.flush)
        else $error("flush bit not cleared in time");
    AST_FLUSH_NOT_READY: assert property (@(posedge core_clk) disable iff (!rstn)
        q.flush |=> !q.pkt_rdy)
        else $error("packet ready during flush");
    AST_OVERRUN: assert property (@(posedge core_clk) disable iff (!rstn)
        (sie_rx_valid && q.iso && full) |=> q.overrun && !fifo_store)
        else $error("overrun not flagged");
    AST_OVERRUN_HOLDS: assert property (@(posedge core_clk) disable iff (!rstn)
        (q.overrun && !(wr_ctrl && !wdat[OVERRUN_POS])) |=> q.overrun)
        else $error("overrun dropped by itself");
    // fifo full as software reads it, one cycle after the address phase
    AST_FULL_DEPTH: assert property (@(posedge core_clk) disable iff (!rstn)
        (rd_ctrl && !q.dbl && q.pkt_cnt == 2'h1) |=> hrdata[FIFO_FULL_POS])
        else $error("single buffer not full with one packet");
    AST_FULL_DOUBLE: assert property (@(posedge core_clk) disable iff (!rstn)
        (rd_ctrl && q.dbl && q.pkt_cnt == 2'h2) |=> hrdata[FIFO_FULL_POS])
        else $error("double buffer not full with two packets");
    AST_NOT_FULL: assert property (@(posedge core_clk) disable iff (!rstn)
        (rd_ctrl && q.pkt_cnt != cap) |=> !hrdata[FIFO_FULL_POS])
        else $error("fifo full with room left");
    AST_PKT_READY: assert property (@(posedge core_clk) disable iff (!rstn)
        (sie_rx_valid && !q.iso && !q.stall_req && !rx_err && !full && !q.flush && !wr_ctrl)
        |=> fifo_store && hs_ack && q.pkt_rdy)
        else $error("packet not made ready");
    AST_STALL_FLAG: assert property (@(posedge core_clk) disable iff (!rstn)
        hs_stall |-> q.stall_sent && q.int_stat[INT_STALL_POS])
        else $error("stall sent flag missing");
    AST_ISO_CRC: assert property (@(posedge core_clk) disable iff (!rstn)
        (sie_rx_valid && q.iso && sie_rx_crc_err && !full) |=> fifo_store && q.data_err)
        else $error("iso crc packet not kept");
    AST_ERR_CLEARS: assert property (@(posedge core_clk) disable iff (!rstn)
        (wr_ctrl && !wdat[PKT_RDY_POS] && q.pkt_rdy && !sie_rx_valid) |=> !q.data_err)
        else $error("data error not cleared");
    AST_RESET_ZERO: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(rstn) |-> ctrl_view(q, full) == CTRL_LOW_RESET)
        else $error("control low not zero after reset");
    // flush side effects and bus housekeeping
    AST_FLUSH_RD_PTR: assert property (@(posedge core_clk) disable iff (!rstn)
        (wr_ctrl && wdat[FLUSH_POS] && !q.flush) |-> ##3 fifo_rd_ptr_rst)
        else $error("read pointer not rewound");
    AST_DROP_AT_END: assert property (@(posedge core_clk) disable iff (!rstn)
        fifo_drop |-> !q.flush && $past(q.flush))
        else $error("packet dropped outside a flush");
    AST_IRQ_LEVEL: assert property (@(posedge core_clk) disable iff (!rstn)
        irq == |(q.int_stat & q.int_mask))
        else $error("interrupt level wrong");
    AST_WORD_ONLY: assert property (@(posedge core_clk) disable iff (!rstn)
        (addr_ok && hwrite && hsize != HSIZE_WORD) |=> !q.wr_pend)
        else $error("narrow write accepted");
    AST_ZERO_WAIT: assert property (@(posedge core_clk) disable iff (!rstn)
        $past(rstn) |-> hreadyout && !hresp)
        else $error("wait state or error response");

    COV_STALL: cover property (@(posedge core_clk) disable iff (!rstn) hs_stall);
    COV_FLUSH: cover property (@(posedge core_clk) disable iff (!rstn) fifo_drop);
    COV_OVERRUN: cover property (@(posedge core_clk) disable iff (!rstn) $rose(q.overrun));
    COV_DBL_FULL: cover property (@(posedge core_clk) disable iff (!rstn)
        q.dbl && q.pkt_cnt == 2'h2);
    COV_DATA_ERR: cover property (@(posedge core_clk) disable iff (!rstn) $rose(q.data_err));
endmodule // usb_out_ep_ctrl

// ### verification/usb_host_model.sv
// usb_host_model: stands in for the usb host seen through the serial engine.
// assumes the engine shares core_clk and its handshake comes one cycle later.
`timescale 1ns/1ps
module usb_host_model (
    input wire logic core_clk,
    output logic sie_rx_valid,
    output logic sie_rx_crc_err,
    output logic sie_rx_stuff_err,
    input wire logic hs_ack,
    input wire logic hs_nak,
    input wire logic hs_stall,
    input wire logic fifo_store
);
    // ----------------------------------------
    // packet delivery
    // ----------------------------------------
    initial begin
        sie_rx_valid = 1'b0;
        sie_rx_crc_err = 1'b0;
        sie_rx_stuff_err = 1'b0;
    end

    // one out packet; resp is {stall, nak, ack, store} as seen one cycle later
    task automatic send(input logic crc, input logic stuff, output logic [3:0] resp);
        @(posedge core_clk);
        sie_rx_valid <= 1'b1;
        sie_rx_crc_err <= crc;
        sie_rx_stuff_err <= stuff;
        @(posedge core_clk);
        sie_rx_valid <= 1'b0;
        // qualifiers mean nothing outside valid, so never leave the old value
        sie_rx_crc_err <= ~crc;
        sie_rx_stuff_err <= ~stuff;
        @(posedge core_clk);
        resp = {hs_stall, hs_nak, hs_ack, fifo_store};
    endtask
endmodule // usb_host_model

// ### verification/test_usb_out_endpoint_ctrl_status.sv
// test_usb_out_endpoint_ctrl_status: self-checking bench for the endpoint block.
// assumes a single ahb-lite slave, zero wait states, and the host model on the sie side.
`timescale 1ns/1ps
module test_usb_out_endpoint_ctrl_status
    import usb_out_ep_pkg::*;
;
    logic core_clk, rstn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic rx_valid, rx_crc, rx_stuff, hs_ack, hs_nak, hs_stall;
    logic fifo_store, fifo_drop, fifo_rd_ptr_rst, data_toggle, irq;
    int mismatches = 0;
    int compares = 0;
    int rst_cnt = 0;
    int drop_cnt = 0;

    // ----------------------------------------
    // design and host
    // ----------------------------------------
    assign hready = hreadyout;
    usb_out_ep_ctrl DUT (.core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sie_rx_valid(rx_valid),
        .sie_rx_crc_err(rx_crc), .sie_rx_stuff_err(rx_stuff), .hs_ack(hs_ack),
        .hs_nak(hs_nak), .hs_stall(hs_stall), .fifo_store(fifo_store),
        .fifo_drop(fifo_drop), .fifo_rd_ptr_rst(fifo_rd_ptr_rst),
        .data_toggle(data_toggle), .irq(irq));
    usb_host_model HOST (.core_clk(core_clk), .sie_rx_valid(rx_valid),
        .sie_rx_crc_err(rx_crc), .sie_rx_stuff_err(rx_stuff), .hs_ack(hs_ack),
        .hs_nak(hs_nak), .hs_stall(hs_stall), .fifo_store(fifo_store));

    // ----------------------------------------
    // clock, pulse counters, watchdog
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // fifo pulses last one cycle, so count them instead of chasing them
    always @(posedge core_clk) begin
        if (fifo_rd_ptr_rst === 1'b1) rst_cnt++;
        if (fifo_drop === 1'b1) drop_cnt++;
    end
    // whole run is a few hundred cycles; this allows ten thousand
    initial begin
        #40000;
        mismatches++;
        complete_run();
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic complete_run();
        if (mismatches == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // one single word transfer; the master waits for hready in each phase
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= HSIZE_WORD;
        @(posedge core_clk);
        while (hready !== 1'b1) @(posedge core_clk);
        htrans <= 2'h0;
        hwdata <= wr ? wd : 32'h00000000;
        @(posedge core_clk);
        while (hready !== 1'b1) @(posedge core_clk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        ahb(1'b1, a, d, unused);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        ahb(1'b0, a, 32'h00000000, v);
        check_val(v, exp);
    endtask

    task automatic pkt(input logic crc, input logic stuff, input logic [3:0] exp);
        logic [3:0] r;
        HOST.send(crc, stuff, r);
        check_val({28'h0000000, r}, {28'h0000000, exp});
    endtask

    task automatic wait_flush();
        logic [31:0] v;
        int n;
        n = 0;
        v = 32'h00000010;
        while (v[FLUSH_POS] === 1'b1 && n < 30) begin
            ahb(1'b0, CTRL_LOW_OFS, 32'h00000000, v);
            n++;
        end
        check_val({31'h0, v[FLUSH_POS]}, 32'h00000000);
    endtask

    // ----------------------------------------
    // scenarios (8'h45 keeps sticky bits and leaves the packet alone)
    // ----------------------------------------
    task automatic test_reset();
        rd_chk(CTRL_LOW_OFS, 32'h00000000);
        rd_chk(INT_STAT_OFS, 32'h00000000);
        rd_chk(8'h40, 32'h00000000);
        check_val({31'h0, hresp}, 32'h00000000);
    endtask

    task automatic test_bulk();
        pkt(1'b1, 1'b0, 4'h0);
        pkt(1'b0, 1'b0, 4'h3);
        rd_chk(CTRL_LOW_OFS, 32'h00000003);
        check_val({31'h0, irq}, 32'h00000000);
        check_val({31'h0, data_toggle}, 32'h00000001);
        wr(INT_MASK_OFS, 32'h00000007);
        rd_chk(INT_STAT_OFS, 32'h00000001);
        check_val({31'h0, irq}, 32'h00000001);
        pkt(1'b0, 1'b0, 4'h4);
        wr(CTRL_LOW_OFS, 32'h000000C5);
        rd_chk(CTRL_LOW_OFS, 32'h00000003);
        check_val({31'h0, data_toggle}, 32'h00000000);
        wr(CTRL_LOW_OFS, 32'h00000044);
        rd_chk(CTRL_LOW_OFS, 32'h00000000);
        wr(INT_STAT_OFS, 32'h00000007);
        rd_chk(INT_STAT_OFS, 32'h00000000);
        check_val({31'h0, irq}, 32'h00000000);
    endtask

    task automatic test_stall();
        wr(CTRL_LOW_OFS, 32'h00000065);
        pkt(1'b0, 1'b0, 4'h8);
        rd_chk(CTRL_LOW_OFS, 32'h00000060);
        rd_chk(INT_STAT_OFS, 32'h00000002);
        check_val({31'h0, irq}, 32'h00000001);
        wr(CTRL_LOW_OFS, 32'h00000025);
        rd_chk(CTRL_LOW_OFS, 32'h00000020);
        wr(CTRL_LOW_OFS, 32'h00000005);
        pkt(1'b0, 1'b0, 4'h3);
        wr(CTRL_LOW_OFS, 32'h00000044);
        wr(EP_CFG_OFS, 32'h00000001);
        wr(CTRL_LOW_OFS, 32'h00000065);
        pkt(1'b0, 1'b0, 4'h1);
        rd_chk(CTRL_LOW_OFS, 32'h00000023);
        wr(CTRL_LOW_OFS, 32'h00000044);
        wr(EP_CFG_OFS, 32'h00000000);
        wr(INT_STAT_OFS, 32'h00000007);
    endtask

    task automatic test_flush();
        logic [31:0] v;
        wr(EP_CFG_OFS, 32'h00000002);
        pkt(1'b0, 1'b0, 4'h3);
        pkt(1'b0, 1'b0, 4'h3);
        rd_chk(CTRL_LOW_OFS, 32'h00000003);
        wr(CTRL_LOW_OFS, 32'h00000055);
        ahb(1'b0, CTRL_LOW_OFS, 32'h00000000, v);
        check_val(v & 32'h00000011, 32'h00000010);
        wait_flush();
        rd_chk(CTRL_LOW_OFS, 32'h00000001);
        check_val(rst_cnt, 32'h00000001);
        check_val(drop_cnt, 32'h00000001);
        wr(CTRL_LOW_OFS, 32'h00000055);
        wait_flush();
        rd_chk(CTRL_LOW_OFS, 32'h00000000);
        check_val(drop_cnt, 32'h00000002);
        wr(EP_CFG_OFS, 32'h00000000);
        wr(INT_STAT_OFS, 32'h00000007);
    endtask

    task automatic test_iso();
        wr(EP_CFG_OFS, 32'h00000001);
        pkt(1'b1, 1'b0, 4'h1);
        rd_chk(CTRL_LOW_OFS, 32'h0000000B);
        pkt(1'b0, 1'b0, 4'h0);
        rd_chk(CTRL_LOW_OFS, 32'h0000000F);
        rd_chk(INT_STAT_OFS, 32'h00000005);
        wr(CTRL_LOW_OFS, 32'h00000045);
        rd_chk(CTRL_LOW_OFS, 32'h0000000F);
        wr(CTRL_LOW_OFS, 32'h00000040);
        rd_chk(CTRL_LOW_OFS, 32'h00000000);
        pkt(1'b0, 1'b1, 4'h1);
        rd_chk(CTRL_LOW_OFS, 32'h0000000B);
        wr(CTRL_LOW_OFS, 32'h00000044);
        rd_chk(CTRL_LOW_OFS, 32'h00000000);
        wr(EP_CFG_OFS, 32'h00000000);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rstn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h00000000;
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge core_clk);
        test_reset();
        test_bulk();
        test_stall();
        test_flush();
        test_iso();
        complete_run();
    end
endmodule // test_usb_out_endpoint_ctrl_status
